// [src/guard_timer_with_unlock.sv]
/*
 * Guard timer with timed unlock: APB slave, control register, unlock
 * window, oscillator edge sampling, time-out counter, reset pulse,
 * reset cause flag and event interrupt.
 * Assumes the oscillator, restart and chip reset inputs are sampled on
 * core_clk_i, and the oscillator runs well below core_clk_i.
 */
// Behaviour
// - Counter advances on rising edges of the separate 1 MHz oscillator.
// - Restart instruction clears the counter to zero.
// - Disabling the timer or any chip reset clears the counter.
// - Enabled timer expiring without restart resets the chip; eight periods.
// - Control bits 7..5 are read-only and read zero.
// - Writing one enables; writing zero disables only while unlock is set.
// - Hardware clears the unlock bit four clock cycles after setting.
// - Select code n expires after 16384 times two to the n cycles.
// - Every control bit resets to zero: disabled, shortest period.
// - Time-out gives a one system clock reset pulse.
// - Time-out sets cause flag; cleared only by power-on or writing zero.
`timescale 1ns/1ns
module guard_timer_with_unlock #(
    parameter int BASE_CYCLES = guard_pkg::BASE_CYCLES_DEF
) (
    input  wire logic                core_clk_i,
    input  wire logic                arst_n_i,
    input  wire guard_pkg::apb_req_s apb_req_i,
    output guard_pkg::apb_rsp_s      apb_rsp_o,
    input  wire logic                osc_clk_i,
    input  wire logic                restart_i,
    input  wire logic                chip_reset_i,
    output logic                     chip_reset_o,
    output logic                     irq_o
);
    import guard_pkg::*;

    guard_control_s       control_reg;
    guard_control_s       control_view;
    logic [UNLOCK_W-1:0]  unlock_cnt_reg;
    logic                 unlock_active;
    logic                 osc_meta_reg;
    logic                 osc_sync_reg;
    logic                 osc_prev_reg;
    logic                 osc_tick;
    logic [CNT_W-1:0]     count_reg;
    logic [CNT_W-1:0]     limit_m1;
    logic                 expire;
    logic                 pulse_reg;
    logic                 sys_reset;
    logic                 cause_reg;
    logic [EVT_W-1:0]     status_reg;
    logic [EVT_W-1:0]     mask_reg;
    logic [EVT_W-1:0]     evt;
    logic [31:0]          rdata_reg;
    logic                 err_reg;
    logic                 setup;
    logic                 access;
    logic                 wr;
    logic                 wr_ctl;

    // Bus phases
    assign setup  = apb_req_i.psel & ~apb_req_i.penable;
    assign access = apb_req_i.psel & apb_req_i.penable;
    assign wr     = access & apb_req_i.pwrite & ~err_reg;
    assign wr_ctl = wr && (apb_req_i.paddr == OFS_CONTROL);

    assign sys_reset     = chip_reset_i | pulse_reg;
    assign unlock_active = (unlock_cnt_reg != '0);

    // Control register
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            control_reg <= CONTROL_RESET;
        end else if (sys_reset) begin
            control_reg <= CONTROL_RESET;
        end else if (wr_ctl) begin
            control_reg.sel    <= apb_req_i.pwdata[SEL_W-1:0];
            control_reg.enable <= apb_req_i.pwdata[BIT_ENABLE]
                | (control_reg.enable & ~unlock_active);
        end
    end

    // Unlock window
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            unlock_cnt_reg <= '0;
        end else if (sys_reset) begin
            unlock_cnt_reg <= '0;
        end else if (wr_ctl && apb_req_i.pwdata[BIT_UNLOCK]) begin
            unlock_cnt_reg <= UNLOCK_W'(UNLOCK_CYCLES);
        end else if (unlock_active) begin
            unlock_cnt_reg <= unlock_cnt_reg - 1'b1;
        end
    end

    // Oscillator edge sampling
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end else begin
            osc_meta_reg <= osc_clk_i;
            osc_sync_reg <= osc_meta_reg;
            osc_prev_reg <= osc_sync_reg;
        end
    end

    assign osc_tick = osc_sync_reg & ~osc_prev_reg;

    // Expiry count from the select field
    assign limit_m1 = (CNT_W'(BASE_CYCLES) << control_reg.sel)
        - CNT_W'(1);
    assign expire = control_reg.enable & osc_tick & ~restart_i
        & ~sys_reset & (count_reg >= limit_m1);

    // Time-out counter
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_reg <= '0;
        end else if (sys_reset || !control_reg.enable) begin
            count_reg <= '0;
        end else if (restart_i) begin
            count_reg <= '0;
        end else if (osc_tick && !expire) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // Reset pulse
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pulse_reg <= 1'b0;
        end else begin
            pulse_reg <= expire;
        end
    end

    assign chip_reset_o = pulse_reg;

    // Reset cause flag, set wins over clear
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cause_reg <= 1'b0;
        end else if (pulse_reg) begin
            cause_reg <= 1'b1;
        end else if (wr && apb_req_i.paddr == OFS_CAUSE
                     && !apb_req_i.pwdata[BIT_CAUSE]) begin
            cause_reg <= 1'b0;
        end
    end

    // Events
    always_comb begin
        evt               = '0;
        evt[EVT_TIMEOUT]  = expire;
        evt[EVT_DISABLED] = wr_ctl & control_reg.enable & unlock_active
            & ~apb_req_i.pwdata[BIT_ENABLE];
        evt[EVT_REFUSED]  = wr_ctl & control_reg.enable & ~unlock_active
            & ~apb_req_i.pwdata[BIT_ENABLE];
    end

    // Status, write one to clear, set wins
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status_reg <= '0;
        end else if (wr && apb_req_i.paddr == OFS_STATUS) begin
            status_reg <= (status_reg & ~apb_req_i.pwdata[EVT_W-1:0]) | evt;
        end else begin
            status_reg <= status_reg | evt;
        end
    end

    // Mask
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mask_reg <= MASK_RESET;
        end else if (wr && apb_req_i.paddr == OFS_MASK) begin
            mask_reg <= apb_req_i.pwdata[EVT_W-1:0];
        end
    end

    assign irq_o = |(status_reg & mask_reg);

    // Control view, reserved bits zero
    always_comb begin
        control_view          = CONTROL_RESET;
        control_view.unlock   = unlock_active;
        control_view.enable   = control_reg.enable;
        control_view.sel      = control_reg.sel;
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_reg <= 32'h0000_0000;
            err_reg   <= 1'b0;
        end else if (setup) begin
            rdata_reg <= 32'h0000_0000;
            err_reg   <= 1'b0;
            unique case (apb_req_i.paddr)
                OFS_CONTROL: rdata_reg[7:0]         <= control_view;
                OFS_CAUSE:   rdata_reg[BIT_CAUSE]   <= cause_reg;
                OFS_STATUS:  rdata_reg[EVT_W-1:0]   <= status_reg;
                OFS_MASK:    rdata_reg[EVT_W-1:0]   <= mask_reg;
                OFS_COUNT:   rdata_reg[CNT_W-1:0]   <= count_reg;
                default:     err_reg                <= 1'b1;
            endcase
        end
    end

    always_comb begin
        apb_rsp_o         = '0;
        apb_rsp_o.prdata  = rdata_reg;
        apb_rsp_o.pready  = access;
        apb_rsp_o.pslverr = access & err_reg;
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    a_restart_clears_count: assert property (
        restart_i |=> count_reg == '0)
        else $error("restart did not clear the counter");

    a_disable_clears_count: assert property (
        !control_reg.enable |=> count_reg == '0)
        else $error("disabled timer kept a count");

    a_chip_reset_clears: assert property (
        chip_reset_i |=> count_reg == '0 && control_reg == CONTROL_RESET)
        else $error("chip reset left control or count");

    a_reserved_read_zero: assert property (
        access && apb_req_i.paddr == OFS_CONTROL
        |-> apb_rsp_o.prdata[31:5] == '0)
        else $error("reserved control bits read nonzero");

    a_enable_write_sets: assert property (
        wr_ctl && apb_req_i.pwdata[BIT_ENABLE] && !sys_reset
        |=> control_reg.enable)
        else $error("enable write did not enable");

    a_disable_needs_unlock: assert property (
        wr_ctl && !unlock_active && control_reg.enable && !sys_reset
        |=> control_reg.enable)
        else $error("locked timer was disabled");

    a_unlock_window_open: assert property (
        wr_ctl && apb_req_i.pwdata[BIT_UNLOCK] && !sys_reset
        && !chip_reset_i |=> unlock_active[*4])
        else $error("unlock window shorter than four cycles");

    a_unlock_window_close: assert property (
        unlock_cnt_reg == UNLOCK_W'(1)
        && !(wr_ctl && apb_req_i.pwdata[BIT_UNLOCK]) |=> !unlock_active)
        else $error("unlock window did not close");

    a_pulse_one_cycle: assert property (
        $rose(chip_reset_o) |=> !chip_reset_o && count_reg == '0
        && !control_reg.enable)
        else $error("reset pulse longer than one cycle");

    a_pulse_cause: assert property (
        chip_reset_o |-> $past(osc_tick) && $past(control_reg.enable)
        && $past(count_reg) >= $past(limit_m1))
        else $error("reset pulse without expiry");

    a_cause_flag_set: assert property (
        chip_reset_o |=> cause_reg ##1 cause_reg)
        else $error("cause flag not set by time-out");

    a_osc_tick_single: assert property (
        osc_tick |=> !osc_tick)
        else $error("oscillator edge seen twice");

    a_count_step: assert property (
        control_reg.enable && osc_tick && !restart_i && !sys_reset
        && !expire |=> count_reg == $past(count_reg) + 1'b1)
        else $error("counter did not advance on a tick");

    a_count_hold: assert property (
        control_reg.enable && !osc_tick && !restart_i && !sys_reset
        |=> $stable(count_reg))
        else $error("counter moved without a tick");

    a_timeout_pulse: assert property (
        control_reg.enable && osc_tick && !restart_i && !sys_reset
        && count_reg >= limit_m1 |=> chip_reset_o)
        else $error("expired timer gave no reset pulse");

    a_timeout_status: assert property (
        chip_reset_o |-> status_reg[EVT_TIMEOUT])
        else $error("time-out event not recorded");

    a_pulse_locks: assert property (
        chip_reset_o |=> !unlock_active)
        else $error("reset pulse left the unlock window open");

    a_unlock_reload: assert property (
        wr_ctl && apb_req_i.pwdata[BIT_UNLOCK] && !sys_reset
        |=> unlock_cnt_reg == UNLOCK_W'(UNLOCK_CYCLES))
        else $error("unlock write did not reload the window");

    a_unlock_countdown: assert property (
        unlock_active && !sys_reset
        && !(wr_ctl && apb_req_i.pwdata[BIT_UNLOCK])
        |=> unlock_cnt_reg == $past(unlock_cnt_reg) - 1'b1)
        else $error("unlock window did not count down");

    a_unlock_bounded: assert property (
        unlock_cnt_reg <= UNLOCK_W'(UNLOCK_CYCLES))
        else $error("unlock window longer than four cycles");

    a_sel_written: assert property (
        wr_ctl && !sys_reset
        |=> control_reg.sel == $past(apb_req_i.pwdata[SEL_W-1:0]))
        else $error("time-out select not written");

    a_restart_keeps_on: assert property (
        restart_i && control_reg.enable && !sys_reset && !wr_ctl
        |=> control_reg.enable)
        else $error("restart disabled the timer");

    a_disable_in_window: assert property (
        wr_ctl && unlock_active && !apb_req_i.pwdata[BIT_ENABLE]
        && !sys_reset |=> !control_reg.enable)
        else $error("unlocked disable not accepted");

    a_chip_rst_locks: assert property (
        chip_reset_i |=> !unlock_active)
        else $error("chip reset left the unlock window open");

    a_cause_kept: assert property (
        cause_reg && !(wr && apb_req_i.paddr == OFS_CAUSE
        && !apb_req_i.pwdata[BIT_CAUSE]) |=> cause_reg)
        else $error("cause flag lost without a clear");

    a_cause_no_set: assert property (
        !cause_reg && !pulse_reg |=> !cause_reg)
        else $error("cause flag set without a time-out");

    a_chip_rst_cause: assert property (
        chip_reset_i && cause_reg && !wr |=> cause_reg)
        else $error("chip reset cleared the cause flag");

endmodule : guard_timer_with_unlock

// [src/guard_pkg.sv]
/*
 * Shared constants and carrier types of the guard timer: register map,
 * control field layout, reset values, unlock window and time-out counts.
 * Assumes a 32-bit APB master and a single system clock domain.
 */
package guard_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_CAUSE   = 8'h04;
    localparam logic [7:0] OFS_STATUS  = 8'h08;
    localparam logic [7:0] OFS_MASK    = 8'h0C;
    localparam logic [7:0] OFS_COUNT   = 8'h10;

    // Control field positions
    localparam int BIT_UNLOCK = 4;
    localparam int BIT_ENABLE = 3;
    localparam int SEL_W      = 3;

    // Reset cause flag position
    localparam int BIT_CAUSE = 3;

    // Event bit positions in status and mask
    localparam int EVT_W        = 3;
    localparam int EVT_TIMEOUT  = 0;
    localparam int EVT_DISABLED = 1;
    localparam int EVT_REFUSED  = 2;

    // Reset values
    localparam logic [7:0]       CONTROL_RESET = 8'h00;
    localparam logic [EVT_W-1:0] MASK_RESET    = 3'h0;

    // Unlock window in system clock cycles
    localparam int UNLOCK_CYCLES = 4;
    localparam int UNLOCK_W      = 3;

    // Time-out counts in oscillator cycles
    localparam int CNT_W            = 22;
    localparam int BASE_CYCLES_DEF  = 16384;

    typedef struct packed {
        logic [2:0]       reserved;
        logic             unlock;
        logic             enable;
        logic [SEL_W-1:0] sel;
    } guard_control_s;

    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_s;

endpackage : guard_pkg

// [testbench/tb_top.sv]
/*
 * Self-checking bench of the guard timer: register table, unlock window,
 * restart, time-out for every select code, interrupt and reset cause.
 * Assumes the design package is compiled first; time-out base set to 4.
 */
`timescale 1ns/1ns
module tb_top;
    import guard_pkg::*;
    typedef struct {
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] q;
        logic        e;
    } row_s;
    logic        core_clk_i;
    logic        arst_n_i;
    logic        osc_clk_i;
    logic        restart_i;
    logic        chip_reset_i;
    logic        chip_reset_o;
    logic        irq_o;
    apb_req_s    req;
    apb_rsp_s    rsp;
    logic [31:0] q;
    logic        e;
    int          num_errors = 0;
    int          checked    = 0;
    int          pulses     = 0;
    int          n;
    int          lim;
    row_s        rows[6];

    guard_timer_with_unlock #(.BASE_CYCLES(4)) guard_timer_with_unlock_i (
        .core_clk_i  (core_clk_i),
        .arst_n_i    (arst_n_i),
        .apb_req_i   (req),
        .apb_rsp_o   (rsp),
        .osc_clk_i   (osc_clk_i),
        .restart_i   (restart_i),
        .chip_reset_i(chip_reset_i),
        .chip_reset_o(chip_reset_o),
        .irq_o       (irq_o)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // Oscillator of 8 core cycles, edges on falling core edges, away from rising ones
    initial begin
        osc_clk_i = 1'b0;
        forever #40 osc_clk_i = ~osc_clk_i;
    end

    always @(posedge core_clk_i) begin
        if (chip_reset_o === 1'b1) pulses <= pulses + 1;
    end

    task wrap_up;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checked++;
        if (got !== ex) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task tick(input int c);
        repeat (c) @(posedge core_clk_i);
    endtask : tick

    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge core_clk_i);
        req.paddr   <= a;
        req.pwrite  <= w;
        req.pwdata  <= d;
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        @(posedge core_clk_i);
        req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk_i);
            k++;
        end while (rsp.pready !== 1'b1 && k < 16);
        if (k >= 16) begin
            num_errors++;
            wrap_up();
        end
        q = rsp.prdata;
        e = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] ex);
        apb(a, 1'b0, 32'h0000_0000);
        chk(nm, ex, q);
    endtask : rd_chk

    task restart;
        @(posedge core_clk_i);
        restart_i <= 1'b1;
        @(posedge core_clk_i);
        restart_i <= 1'b0;
    endtask : restart

    initial begin
        arst_n_i     = 1'b0;
        restart_i    = 1'b0;
        chip_reset_i = 1'b0;
        req          = '0;
        rows[0] = '{OFS_CONTROL, 32'h0000_00E7, 32'h0000_0007, 1'b0};
        rows[1] = '{OFS_CONTROL, 32'h0000_000F, 32'h0000_000F, 1'b0};
        rows[2] = '{OFS_CONTROL, 32'h0000_0007, 32'h0000_000F, 1'b0};
        rows[3] = '{OFS_MASK, 32'h0000_0005, 32'h0000_0005, 1'b0};
        rows[4] = '{OFS_MASK, 32'h0000_0001, 32'h0000_0001, 1'b0};
        rows[5] = '{8'h20, 32'h0000_0001, 32'h0000_0000, 1'b1};
        tick(3);
        arst_n_i <= 1'b1;
        rd_chk("control reset", OFS_CONTROL, 32'h0000_0000);
        rd_chk("mask reset", OFS_MASK, 32'h0000_0000);
        foreach (rows[i]) begin
            apb(rows[i].a, 1'b1, rows[i].d);
            apb(rows[i].a, 1'b0, 32'h0000_0000);
            chk("row data", rows[i].q, q);
            chk("row error", {31'h0, rows[i].e}, {31'h0, e});
        end
        // Late disable refused, prompt disable accepted
        restart();
        apb(OFS_CONTROL, 1'b1, 32'h0000_0018);
        rd_chk("window open", OFS_CONTROL, 32'h0000_0018);
        apb(OFS_CONTROL, 1'b1, 32'h0000_0000);
        rd_chk("late disable", OFS_CONTROL, 32'h0000_0008);
        apb(OFS_CONTROL, 1'b1, 32'h0000_0018);
        apb(OFS_CONTROL, 1'b1, 32'h0000_0000);
        rd_chk("disabled", OFS_CONTROL, 32'h0000_0000);
        rd_chk("count cleared", OFS_COUNT, 32'h0000_0000);
        rd_chk("status events", OFS_STATUS, 32'h0000_0006);
        apb(OFS_STATUS, 1'b1, 32'h0000_0007);
        // Regular restarts keep the shortest period from expiring
        apb(OFS_CONTROL, 1'b1, 32'h0000_0008);
        n = pulses;
        repeat (20) begin
            restart();
            tick(14);
        end
        chk("no expiry", n, pulses);
        for (int s = 0; s < 8; s++) begin
            apb(OFS_CONTROL, 1'b1, 32'h0000_0008 | s);
            restart();
            lim = (4 << s) * 8;
            n = 0;
            do begin
                @(posedge core_clk_i);
                n++;
            end while (chip_reset_o !== 1'b1 && n < lim + 24);
            chk("expiry time", n >= lim - 8 && n <= lim + 16, 1);
            @(posedge core_clk_i);
            chk("pulse width", chip_reset_o, 0);
            rd_chk("ctrl after", OFS_CONTROL, 32'h0000_0000);
            rd_chk("cause set", OFS_CAUSE, 32'h0000_0008);
        end
        chk("irq raised", irq_o, 1);
        apb(OFS_MASK, 1'b1, 32'h0000_0000);
        tick(1);
        chk("irq masked", irq_o, 0);
        apb(OFS_MASK, 1'b1, 32'h0000_0001);
        apb(OFS_STATUS, 1'b1, 32'h0000_0001);
        tick(1);
        chk("irq cleared", irq_o, 0);
        apb(OFS_CAUSE, 1'b1, 32'hFFFF_FFFF);
        rd_chk("cause kept", OFS_CAUSE, 32'h0000_0008);
        apb(OFS_CONTROL, 1'b1, 32'h0000_000B);
        @(posedge core_clk_i);
        chip_reset_i <= 1'b1;
        @(posedge core_clk_i);
        chip_reset_i <= 1'b0;
        rd_chk("ctrl chip rst", OFS_CONTROL, 32'h0000_0000);
        rd_chk("cause chip rst", OFS_CAUSE, 32'h0000_0008);
        apb(OFS_CAUSE, 1'b1, 32'h0000_0000);
        rd_chk("cause clear", OFS_CAUSE, 32'h0000_0000);
        // Time-out again, then power-on reset clears the cause flag
        apb(OFS_CONTROL, 1'b1, 32'h0000_0008);
        restart();
        tick(48);
        rd_chk("cause again", OFS_CAUSE, 32'h0000_0008);
        arst_n_i <= 1'b0;
        tick(2);
        arst_n_i <= 1'b1;
        rd_chk("cause por", OFS_CAUSE, 32'h0000_0000);
        rd_chk("mask por", OFS_MASK, 32'h0000_0000);
        rd_chk("status por", OFS_STATUS, 32'h0000_0000);
        rd_chk("ctrl por", OFS_CONTROL, 32'h0000_0000);
        chk("irq por", irq_o, 0);
        wrap_up();
    end
endmodule : tb_top
